// ===== sync_serial_regs.svh
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

// register byte offsets
`define OFS_CONTROL      4'h0
`define OFS_STATUS       4'h4
`define OFS_TX_BUFFER    4'h8
`define OFS_RX_BUFFER    4'hC

// control register fields
`define CTRL_RUN         0
`define CTRL_FORCE_STOP  1
`define CTRL_MODE_LO     2
`define CTRL_MODE_HI     3
`define CTRL_BIT_ORDER   4
`define CTRL_INT_CLOCK   5

// status register fields
`define STAT_ACTIVE      0
`define STAT_SHIFTING    1
`define STAT_RX_FULL     2
`define STAT_TX_EMPTY    3
`define STAT_RX_ERROR    4
`define STAT_TX_ERROR    5

// transfer mode encodings
`define MODE_TX_ONLY     2'h0
`define MODE_RX_ONLY     2'h1
`define MODE_TXRX        2'h2

// reset values
`define RST_BUFFER       8'h00
`define RST_TX_EMPTY     1'b1

// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// timing
`define CLK_PERIOD_NS    4
`define SCK_HALF_NS      16
`define SCK_HALF_CYC     ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== sync_serial_pkg.sv
package sync_serial_pkg;
  typedef enum logic {ST_IDLE, ST_BYTE} engine_state_t;
endpackage

// ===== sync_serial_rx_txrx.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "sync_serial_regs.svh"

module sync_serial_rx_txrx
  import sync_serial_pkg::*;
#(
  parameter int SCK_HALF = `SCK_HALF_CYC
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial pins
  input  wire logic        serial_clock_pin_level,
  output logic             serial_clock_pin_drive,
  output wire logic        serial_clock_pin_oe,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // event
  output logic             serial_interrupt
);

  default clocking prop_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
    out_bit = lsb ? sh[0] : sh[7];
  endfunction
  // control and status state
  logic                transfer_run_bit;
  logic                force_stop_bit;
  logic [1:0]          transfer_mode_field;
  logic                bit_order_select;
  logic                clock_internal;
  logic                transfer_active_flag;
  logic                receive_full_flag;
  logic                transmit_empty_flag;
  logic                receive_error_flag;
  logic                transmit_error_flag;
  logic [7:0]          receive_buffer;
  logic [7:0]          transmit_buffer;
  logic [7:0]          shift_reg;
  logic [2:0]          bit_count;
  logic                empty_pending;
  logic                recovery_second;
  engine_state_t       state;
  // bus state
  logic                aw_held;
  logic                w_held;
  logic [3:0]          aw_addr;
  logic [31:0]         w_data;
  logic                w_lane0;
  // pin sampling and clock generator
  logic                sck_meta;
  logic                sck_sync;
  logic                sck_prev;
  logic                si_meta;
  logic                si_sync;
  logic [7:0]          div_count;
  // bus decode
  wire logic aw_fire   = s_axi_awvalid && s_axi_awready;
  wire logic w_fire    = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire   = aw_held && w_held && !s_axi_bvalid;
  wire logic rd_fire   = s_axi_arvalid && s_axi_arready;
  wire logic wr_lane   = wr_fire && w_lane0;
  wire logic ctrl_wr   = wr_lane && (aw_addr == `OFS_CONTROL);
  wire logic stat_wr   = wr_lane && (aw_addr == `OFS_STATUS);
  wire logic tx_wr     = wr_lane && (aw_addr == `OFS_TX_BUFFER);
  wire logic rx_rd     = rd_fire && (s_axi_araddr == `OFS_RX_BUFFER);
  wire logic wr_mapped = (aw_addr[1:0] == 2'h0);
  wire logic rd_mapped = (s_axi_araddr[1:0] == 2'h0);

  assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = clk_en && !w_held && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  wire logic mode_rx   = (transfer_mode_field == `MODE_RX_ONLY);
  wire logic mode_txrx = (transfer_mode_field == `MODE_TXRX);
  wire logic mode_ok   = mode_rx || mode_txrx;
  wire logic shift_active = (state == ST_BYTE);
  // the status bit drops at the eighth falling edge; the engine still waits for the last rise
  wire logic low_phase    = clock_internal ? !serial_clock_pin_drive : !sck_prev;
  wire logic shift_flag   = shift_active && !((bit_count == 3'h7) && low_phase);
  // internal clock runs through a byte, and only starts the next one when the buffers allow it (auto wait)
  wire logic int_ready = !receive_full_flag && (mode_rx || !transmit_empty_flag);
  wire logic gen_run   = shift_active || (transfer_run_bit && mode_ok && int_ready);
  wire logic gen_tick  = gen_run && (div_count == 8'(SCK_HALF - 1));
  wire logic fall_int  = gen_tick && serial_clock_pin_drive;
  wire logic rise_int  = gen_tick && !serial_clock_pin_drive;
  wire logic fall_ext  = sck_prev && !sck_sync;
  wire logic rise_ext  = !sck_prev && sck_sync;
  wire logic fall_ev   = clock_internal ? fall_int : fall_ext;
  wire logic rise_ev   = clock_internal ? rise_int : rise_ext;
  wire logic start_byte = fall_ev && !shift_active && transfer_run_bit && mode_ok;
  wire logic rise_byte  = rise_ev && shift_active;
  wire logic byte_done  = rise_byte && (bit_count == 3'h7);
  wire logic [7:0] shifted = bit_order_select ? {si_sync, shift_reg[7:1]}
                                              : {shift_reg[6:0], si_sync};
  wire logic done_ok    = byte_done && !receive_error_flag && !receive_full_flag;
  wire logic done_over  = byte_done && !receive_error_flag && receive_full_flag;
  wire logic [7:0] ctrl_word = {2'h0, clock_internal, bit_order_select,
                                transfer_mode_field, force_stop_bit, transfer_run_bit};
  wire logic [7:0] stat_word = {2'h0, transmit_error_flag, receive_error_flag,
                                transmit_empty_flag, receive_full_flag,
                                shift_flag, transfer_active_flag};
  wire logic [7:0] rx_view   = (receive_error_flag && recovery_second) ? shift_reg
                                                                       : receive_buffer;
  wire logic [7:0] rd_byte   = (s_axi_araddr == `OFS_CONTROL)   ? ctrl_word :
                               (s_axi_araddr == `OFS_STATUS)    ? stat_word :
                               (s_axi_araddr == `OFS_TX_BUFFER) ? transmit_buffer :
                                                                  rx_view;
  assign serial_clock_pin_oe = clock_internal;
  // bus slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0000_0000;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rdata  <= rd_mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // pin synchronisers and the internal clock divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_meta  <= 1'b1;
      sck_sync  <= 1'b1;
      sck_prev  <= 1'b1;
      si_meta   <= 1'b1;
      si_sync   <= 1'b1;
      div_count <= 8'h00;
      serial_clock_pin_drive <= 1'b1;
    end else if (clk_en) begin
      sck_meta <= serial_clock_pin_level;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      si_meta  <= serial_in_pin;
      si_sync  <= si_meta;
      if (force_stop_bit || !gen_run || !clock_internal) begin
        div_count              <= 8'h00;
        serial_clock_pin_drive <= 1'b1;
      end else if (gen_tick) begin
        div_count              <= 8'h00;
        serial_clock_pin_drive <= !serial_clock_pin_drive;
      end else begin
        div_count <= div_count + 8'h01;
      end
    end
  end
  // registers and shift engine; hardware sets come last so they win over clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transfer_run_bit     <= 1'b0;
      force_stop_bit       <= 1'b0;
      transfer_mode_field  <= `MODE_TX_ONLY;
      bit_order_select     <= 1'b0;
      clock_internal       <= 1'b0;
      transfer_active_flag <= 1'b0;
      receive_full_flag    <= 1'b0;
      transmit_empty_flag  <= `RST_TX_EMPTY;
      receive_error_flag   <= 1'b0;
      transmit_error_flag  <= 1'b0;
      receive_buffer       <= `RST_BUFFER;
      transmit_buffer      <= `RST_BUFFER;
      shift_reg            <= `RST_BUFFER;
      bit_count            <= 3'h0;
      empty_pending        <= 1'b0;
      recovery_second      <= 1'b0;
      state                <= ST_IDLE;
      serial_out_pin       <= 1'b1;
      serial_interrupt     <= 1'b0;
    end else if (clk_en) begin
      serial_interrupt <= 1'b0;
      if (force_stop_bit) begin
        force_stop_bit       <= 1'b0;
        transfer_run_bit     <= 1'b0;
        transfer_active_flag <= 1'b0;
        receive_full_flag    <= 1'b0;
        transmit_empty_flag  <= `RST_TX_EMPTY;
        receive_error_flag   <= 1'b0;
        transmit_error_flag  <= 1'b0;
        receive_buffer       <= `RST_BUFFER;
        transmit_buffer      <= `RST_BUFFER;
        bit_count            <= 3'h0;
        empty_pending        <= 1'b0;
        recovery_second      <= 1'b0;
        state                <= ST_IDLE;
        serial_out_pin       <= 1'b1;
      end else begin
        // software side
        if (ctrl_wr) begin
          transfer_run_bit    <= w_data[`CTRL_RUN];
          force_stop_bit      <= w_data[`CTRL_FORCE_STOP];
          transfer_mode_field <= w_data[`CTRL_MODE_HI:`CTRL_MODE_LO];
          bit_order_select    <= w_data[`CTRL_BIT_ORDER];
          clock_internal      <= w_data[`CTRL_INT_CLOCK];
        end
        if (stat_wr && w_data[`STAT_RX_ERROR]) begin
          receive_error_flag <= 1'b0;
          receive_full_flag  <= 1'b0;
          recovery_second    <= 1'b0;
        end
        if (stat_wr && w_data[`STAT_TX_ERROR]) begin
          transmit_error_flag <= 1'b0;
        end
        if (tx_wr) begin
          transmit_buffer     <= w_data[7:0];
          transmit_empty_flag <= 1'b0;
        end
        if (rx_rd && !receive_error_flag) begin
          receive_full_flag <= 1'b0;
        end
        if (rx_rd && receive_error_flag) begin
          recovery_second <= 1'b1;
        end
        // idle with run cleared: the byte in progress has already ended
        if (!shift_active && !transfer_run_bit) begin
          transfer_active_flag <= 1'b0;
          serial_out_pin       <= 1'b1;
        end
        // serial side
        unique case (state)
          ST_IDLE: begin
            if (start_byte) begin
              state                <= ST_BYTE;
              transfer_active_flag <= 1'b1;
              bit_count            <= 3'h0;
              if (mode_txrx && transmit_empty_flag) begin
                transmit_error_flag <= 1'b1;
                serial_out_pin      <= 1'b1;
              end else if (mode_txrx && !receive_error_flag) begin
                shift_reg      <= transmit_buffer;
                serial_out_pin <= out_bit(transmit_buffer, bit_order_select);
                empty_pending  <= 1'b1;
              end else begin
                serial_out_pin <= 1'b1;
              end
            end
          end
          ST_BYTE: begin
            if (fall_ev && mode_txrx && !transmit_error_flag && !receive_error_flag) begin
              serial_out_pin <= out_bit(shift_reg, bit_order_select);
            end
            if (rise_byte) begin
              bit_count <= bit_count + 3'h1;
              if (!receive_error_flag) begin
                shift_reg <= shifted;
              end
              if (empty_pending) begin
                empty_pending       <= 1'b0;
                transmit_empty_flag <= 1'b1;
              end
            end
            if (byte_done) begin
              state <= ST_IDLE;
              if (!transfer_run_bit) begin
                transfer_active_flag <= 1'b0;
                serial_out_pin       <= 1'b1;
              end
              if (done_ok) begin
                receive_buffer    <= shifted;
                receive_full_flag <= 1'b1;
                serial_interrupt  <= 1'b1;
              end
              if (done_over) begin
                receive_error_flag <= 1'b1;
                recovery_second    <= 1'b0;
                serial_interrupt   <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  property p_active_on_fall;
    $rose(transfer_active_flag) |-> $past(fall_ev);
  endproperty
  a_active_on_fall: assert property (p_active_on_fall) else $error("active not on fall");
  property p_shift_in_active;
    $rose(shift_active) |-> transfer_active_flag && $past(fall_ev);
  endproperty
  a_shift_in_active: assert property (p_shift_in_active) else $error("shift flag bad");
  property p_byte_to_buffer;
    clk_en && done_ok && !force_stop_bit |=>
      receive_full_flag && serial_interrupt && (receive_buffer == $past(shifted));
  endproperty
  a_byte_to_buffer: assert property (p_byte_to_buffer) else $error("byte not stored");
  property p_read_clears_full;
    clk_en && rx_rd && !receive_error_flag && !done_ok && !force_stop_bit
      |=> !receive_full_flag;
  endproperty
  a_read_clears_full: assert property (p_read_clears_full) else $error("full kept");
  property p_overrun_error;
    clk_en && done_over && !force_stop_bit |=> receive_error_flag && serial_interrupt;
  endproperty
  a_overrun_error: assert property (p_overrun_error) else $error("overrun missed");
  property p_error_keeps_buffer;
    receive_error_flag && !force_stop_bit |=> $stable(receive_buffer);
  endproperty
  a_error_keeps_buffer: assert property (p_error_keeps_buffer) else $error("buffer moved");
  property p_no_irq_in_error;
    serial_interrupt |-> !$past(receive_error_flag);
  endproperty
  a_no_irq_in_error: assert property (p_no_irq_in_error) else $error("irq during error");
  property p_force_stop;
    clk_en && force_stop_bit |=> !transfer_run_bit && !transfer_active_flag
      && !receive_full_flag && transmit_empty_flag && (receive_buffer == 8'h00);
  endproperty
  a_force_stop: assert property (p_force_stop) else $error("force stop incomplete");
  property p_force_self_clear;
    clk_en && force_stop_bit |=> !force_stop_bit;
  endproperty
  a_force_self_clear: assert property (p_force_self_clear) else $error("stop bit stuck");
  property p_empty_after_load;
    clk_en && rise_byte && empty_pending && !force_stop_bit |=> transmit_empty_flag;
  endproperty
  a_empty_after_load: assert property (p_empty_after_load) else $error("empty not set");
  property p_stop_out_high;
    $fell(transfer_active_flag) |-> serial_out_pin && !shift_active;
  endproperty
  a_stop_out_high: assert property (p_stop_out_high) else $error("stop output low");

endmodule

// ===== serial_peer.sv
`timescale 1ns/100ps

module serial_peer (
  // pins
  input  wire logic       sck_wire,
  input  wire logic       dev_out,
  output logic            ext_clk,
  output logic            peer_data,
  // setup and view
  input  wire logic       lsb_first,
  output logic [7:0]      peer_seen
);
  logic [7:0] src;
  initial begin
    ext_clk   = 1'b1;
    peer_data = 1'b1;
    src       = 8'h00;
    peer_seen = 8'h00;
  end
  task automatic load(input logic [7:0] b);
    src = b;
  endtask
  // clock stands high between frames
  task automatic clock_byte();
    #1;  // keep pin edges off the system clock edge so the synchronisers never race them
    repeat (8) begin
      #16 ext_clk = 1'b0;
      #16 ext_clk = 1'b1;
    end
  endtask
  // refill with inverted bits so a stale line never looks like fresh data
  always @(negedge sck_wire) begin
    peer_data <= lsb_first ? src[0] : src[7];
    src       <= lsb_first ? {~src[0], src[7:1]} : {src[6:0], ~src[7]};
  end
  always @(posedge sck_wire) begin
    peer_seen <= lsb_first ? {dev_out, peer_seen[7:1]} : {peer_seen[6:0], dev_out};
  end
endmodule

// ===== sync_serial_rx_txrx_tb.sv
`timescale 1ns/100ps
`include "sync_serial_regs.svh"

module sync_serial_rx_txrx_tb;
  import sync_serial_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic [31:0] wdata = 0, rd;
  logic [1:0] rr, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, sck_drive, sck_oe, so, irq, ext_clk, sdata;
  logic lsb = 0, en = 1;
  logic [31:0] rdata;
  logic [7:0] seen;
  wire sck_wire = sck_oe ? sck_drive : ext_clk;
  int miscompares = 0, checks_done = 0, irqs = 0, cycles = 0;

  always #2 aclk = ~aclk;

  sync_serial_rx_txrx sync_serial_rx_txrx_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_pin_level(sck_wire), .serial_clock_pin_drive(sck_drive),
    .serial_clock_pin_oe(sck_oe), .serial_in_pin(sdata), .serial_out_pin(so),
    .serial_interrupt(irq));
  serial_peer serial_peer_inst (.sck_wire(sck_wire), .dev_out(so), .ext_clk(ext_clk),
    .peer_data(sdata), .lsb_first(lsb), .peer_seen(seen));

  always @(posedge aclk) begin
    if (irq === 1'b1) irqs <= irqs + 1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'h1; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 0; end
      if (!w && wready === 1'b1) begin w = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
  endtask
  task automatic axi_read(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 0;
  endtask
  task automatic read_check(input logic [3:0] a, input logic [31:0] exp);
    axi_read(a);
    check_val(rd, exp);
  endtask
  task automatic wait_full();
    int n;
    n = 0;
    do begin axi_read(`OFS_STATUS); n++; end while (rd[`STAT_RX_FULL] !== 1'b1 && n < 300);
  endtask
  task automatic ext_byte(input logic [7:0] b);
    serial_peer_inst.load(b);
    serial_peer_inst.clock_byte();
    repeat (10) @(posedge aclk);
  endtask

  task automatic t_reset();
    read_check(`OFS_CONTROL, 32'h0000_0000);
    read_check(`OFS_STATUS, 32'h0000_0008);
    read_check(`OFS_RX_BUFFER, 32'h0000_0000);
    axi_read(4'h2);
    check_val({30'h0, rr}, {30'h0, `RESP_SLVERR});
    @(posedge aclk);
    en <= 0;
    @(posedge aclk);
    check_val({31'h0, arready}, 32'h0000_0000);
    en <= 1;
    $display("t_reset done");
  endtask
  task automatic t_rx_int();
    int i0;
    i0 = irqs;
    serial_peer_inst.load(8'hA5);
    axi_write(`OFS_CONTROL, 32'h0000_0025);
    wait_full();
    check_val(rd, 32'h0000_000D);
    repeat (40) @(posedge aclk);
    check_val({31'h0, sck_drive}, 32'h0000_0001);
    check_val(irqs - i0, 32'h0000_0001);
    serial_peer_inst.load(8'h3C);
    read_check(`OFS_RX_BUFFER, 32'h0000_00A5);
    axi_read(`OFS_STATUS);
    check_val({31'h0, rd[`STAT_RX_FULL]}, 32'h0000_0000);
    wait_full();
    axi_write(`OFS_CONTROL, 32'h0000_0024);
    read_check(`OFS_RX_BUFFER, 32'h0000_003C);
    read_check(`OFS_STATUS, 32'h0000_0008);
    $display("t_rx_int done");
  endtask
  task automatic force_stop();
    axi_write(`OFS_CONTROL, 32'h0000_0002);
    read_check(`OFS_CONTROL, 32'h0000_0000);
    read_check(`OFS_STATUS, 32'h0000_0008);
    read_check(`OFS_RX_BUFFER, 32'h0000_0000);
  endtask
  task automatic t_txrx_int();
    force_stop();
    lsb = 1;
    axi_write(`OFS_TX_BUFFER, 32'h0000_0096);
    read_check(`OFS_STATUS, 32'h0000_0000);
    serial_peer_inst.load(8'hC3);
    axi_write(`OFS_CONTROL, 32'h0000_0039);
    wait_full();
    read_check(`OFS_RX_BUFFER, 32'h0000_00C3);
    check_val({24'h0, seen}, 32'h0000_0096);
    repeat (40) @(posedge aclk);
    read_check(`OFS_STATUS, 32'h0000_0009);
    check_val({31'h0, sck_drive}, 32'h0000_0001);
    serial_peer_inst.load(8'h5A);
    axi_write(`OFS_TX_BUFFER, 32'h0000_0066);
    wait_full();
    read_check(`OFS_RX_BUFFER, 32'h0000_005A);
    check_val({24'h0, seen}, 32'h0000_0066);
    axi_write(`OFS_CONTROL, 32'h0000_0038);
    read_check(`OFS_STATUS, 32'h0000_0008);
    check_val({31'h0, so}, 32'h0000_0001);
    lsb = 0;
    $display("t_txrx_int done");
  endtask
  task automatic t_rx_ext_err();
    int i0;
    force_stop();
    i0 = irqs;
    axi_write(`OFS_CONTROL, 32'h0000_0005);
    ext_byte(8'h81);
    read_check(`OFS_STATUS, 32'h0000_000D);
    ext_byte(8'h42);
    read_check(`OFS_STATUS, 32'h0000_001D);
    check_val(irqs - i0, 32'h0000_0002);
    ext_byte(8'hFF);
    check_val(irqs - i0, 32'h0000_0002);
    axi_write(`OFS_CONTROL, 32'h0000_0004);
    read_check(`OFS_RX_BUFFER, 32'h0000_0081);
    read_check(`OFS_RX_BUFFER, 32'h0000_0042);
    axi_write(`OFS_STATUS, 32'h0000_0010);
    read_check(`OFS_STATUS, 32'h0000_0008);
    $display("t_rx_ext_err done");
  endtask
  task automatic t_txrx_ext();
    force_stop();
    axi_write(`OFS_CONTROL, 32'h0000_0009);
    ext_byte(8'h18);
    read_check(`OFS_STATUS, 32'h0000_002D);
    check_val({24'h0, seen}, 32'h0000_00FF);
    force_stop();
    axi_write(`OFS_TX_BUFFER, 32'h0000_00E7);
    axi_write(`OFS_CONTROL, 32'h0000_0009);
    ext_byte(8'h24);
    check_val({24'h0, seen}, 32'h0000_00E7);
    read_check(`OFS_RX_BUFFER, 32'h0000_0024);
    // the buffer read above has already dropped receive-full
    read_check(`OFS_STATUS, 32'h0000_0009);
    $display("t_txrx_ext done");
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_rx_int();
    t_txrx_int();
    t_rx_ext_err();
    t_txrx_ext();
    report_and_stop();
  end
endmodule
